// file: dv/btd_ctrl_model.sv
// Bus controller model that sends characters to the decoder.
`timescale 1ns/1ps
module btd_ctrl_model (
    input wire logic clk_in,
    output btd_pkg::btd_char_t bus_out
);
    import btd_pkg::*;

    // The bus starts idle and listening in data mode.
    initial begin
        bus_out = '{attention: 1'b0, listen: 1'b1, valid: 1'b0, data: 7'h00};
    end

    // Sends one character, holding valid well past the strobe and spacing the next byte.
    task automatic send_char(input logic [6:0] ch, input logic atn, input logic lsn);
        @(negedge clk_in);
        bus_out.attention = atn;
        bus_out.listen = lsn;
        bus_out.data = ch;
        @(negedge clk_in);
        bus_out.valid = 1'b1;
        repeat (40) @(negedge clk_in);
        bus_out.valid = 1'b0;
        bus_out.data = ~ch; // Released data lines do not keep the last value.
        repeat (12) @(negedge clk_in);
    endtask : send_char
endmodule : btd_ctrl_model

// file: dv/testbench.sv
// Self-checking testbench for the bus band and tuning decoder.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
    import btd_pkg::*;
    logic clk_in;
    logic rst_n_in;
    btd_char_t bus;
    logic strobe;
    logic latch_en;
    logic [3:0] band;
    logic entry;
    logic [15:0] code;
    logic code_ok;
    int error_cnt = 0;
    int checks = 0;
    int strobes = 0;
    int le_cnt = 0;

    btd_ctrl_model i_ctrl (.clk_in(clk_in), .bus_out(bus));

    btd_decoder i_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .attention_in(bus.attention),
        .listen_in(bus.listen), .byte_valid_in(bus.valid), .data_in(bus.data),
        .data_strobe_out(strobe), .remote_band_latch_enable_out(latch_en),
        .band_select_out(band), .tuning_entry_out(entry), .tune_code_out(code),
        .code_valid_out(code_ok)
    );

    // Clock and event counters for strobes and latch enable cycles.
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge strobe) strobes++;
    always @(posedge clk_in) if (latch_en === 1'b1) le_cnt++;

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic send(input logic [6:0] ch);
        i_ctrl.send_char(ch, 1'b0, 1'b1);
    endtask : send

    // Every band number after a band command selects one line through the latch enable.
    task automatic t_band();
        int l0;
        int s0;
        s0 = strobes;
        for (int i = 0; i < 4; i++) begin
            l0 = le_cnt;
            send(7'h42);
            `CHK("latch_early", 1'b0, le_cnt > l0)
            send(7'h31 + 7'(i));
            `CHK("latch_en", 1'b1, le_cnt > l0)
            `CHK("band", 4'h1 << i, band)
        end
        `CHK("strobes", 8, strobes - s0)
        send(7'h42);
        send(7'h35);
        `CHK("band_range", 4'h8, band)
    endtask : t_band

    // Five digits keep the newest four, held back until execute.
    task automatic t_tune();
        send(7'h56);
        `CHK("entry_set", 1'b1, entry)
        for (int i = 1; i <= 5; i++) send(7'h30 + 7'(i));
        `CHK("code_held", 16'h0000, code)
        send(7'h45);
        `CHK("code", 16'h2345, code)
        `CHK("entry_clr", 1'b0, entry)
        `CHK("code_ok", 1'b1, code_ok)
    endtask : t_tune

    // Characters under attention or while not listening are ignored.
    task automatic t_refuse();
        int s0;
        s0 = strobes;
        i_ctrl.send_char(7'h56, 1'b1, 1'b1);
        i_ctrl.send_char(7'h56, 1'b0, 1'b0);
        `CHK("entry_refused", 1'b0, entry)
        `CHK("no_strobe", 0, strobes - s0)
    endtask : t_refuse

    // Band and mode commands end an entry and transfer the cleared and refilled digits.
    task automatic t_end();
        send(7'h56);
        send(7'h39);
        send(7'h38);
        send(7'h42);
        `CHK("code_b", 16'h0098, code)
        `CHK("entry_b", 1'b0, entry)
        send(7'h32);
        `CHK("band_b", 4'h2, band)
        send(7'h56);
        send(7'h37);
        send(7'h4d);
        `CHK("code_m", 16'h0007, code)
        `CHK("entry_m", 1'b0, entry)
    endtask : t_end

    // Watchdog far beyond the expected run of about 1470 cycles.
    initial begin
        repeat (6000) @(posedge clk_in);
        error_cnt++;
        close_out();
    end

    // Reset, then the scenarios in order.
    initial begin
        rst_n_in = 1'b0;
        repeat (6) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (2) @(negedge clk_in);
        `CHK("band_rst", 4'h0, band)
        `CHK("code_rst", 16'h0000, code)
        `CHK("entry_rst", 1'b0, entry)
        `CHK("code_ok_rst", 1'b0, code_ok)
        `CHK("strobe_rst", 1'b0, strobe)
        `CHK("latch_rst", 1'b0, latch_en)
        t_band();
        t_tune();
        t_refuse();
        t_end();
        close_out();
    end
endmodule : testbench

// file: hw/btd_consts.svh
// Constants for the bus band and tuning decoder.
`ifndef BTD_CONSTS_SVH
`define BTD_CONSTS_SVH

`define BTD_CHAR_BAND 7'h42
`define BTD_CHAR_VOLT 7'h56
`define BTD_CHAR_EXEC 7'h45
`define BTD_CHAR_MODE 7'h4d
`define BTD_CHAR_ZERO 7'h30
`define BTD_CHAR_NINE 7'h39
`define BTD_CHAR_BAND_FIRST 7'h31
`define BTD_CHAR_BAND_LAST 7'h34
`define BTD_DIGIT_LSB 0
`define BTD_DIGIT_WIDTH 4
`define BTD_DIGITS 4
`define BTD_TUNE_RESET 16'h0000
`define BTD_BAND_RESET 4'h0
`define BTD_DAC_LEVELS 10000
`define BTD_STROBE_NS 300
`define BTD_CLK_MHZ 100
`define BTD_STROBE_CYCLES ((`BTD_STROBE_NS * `BTD_CLK_MHZ) / 1000)

`endif

// file: hw/btd_decoder.sv
// Command decoder turning bus characters into band select and tuning code.
`timescale 1ns/1ps
`include "btd_consts.svh"
module btd_decoder #(
    parameter int STROBE_CYCLES = `BTD_STROBE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic attention_in,
    input wire logic listen_in,
    input wire logic byte_valid_in,
    input wire logic [6:0] data_in,
    output logic data_strobe_out,
    output logic remote_band_latch_enable_out,
    output logic [3:0] band_select_out,
    output logic tuning_entry_out,
    output logic [15:0] tune_code_out,
    output logic code_valid_out
);
    import btd_pkg::*;

    // Two-stage synchronisers for all pins from the bus.
    logic [9:0] sync1;
    logic [9:0] sync2;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1 <= 10'h000;
            sync2 <= 10'h000;
        end else begin
            sync1 <= {attention_in, listen_in, byte_valid_in, data_in};
            sync2 <= sync1;
        end
    end

    btd_char_t rx;
    assign rx = btd_char_t'(sync2);

    // Detect the start of each valid byte.
    logic valid_d;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valid_d <= 1'b0;
        end else begin
            valid_d <= rx.valid;
        end
    end

    wire byte_start = rx.valid && !valid_d && rx.listen && !rx.attention;

    // Data strobe pulse width counter and latched character.
    logic [7:0] strobe_cnt;
    logic [6:0] held_char;
    wire strobe_active = (strobe_cnt != 8'h00);
    wire strobe_last = (strobe_cnt == 8'h01);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strobe_cnt <= 8'h00;
            held_char <= 7'h00;
        end else if (byte_start && !strobe_active) begin
            strobe_cnt <= 8'(STROBE_CYCLES);
            held_char <= rx.data;
        end else if (strobe_active) begin
            strobe_cnt <= strobe_cnt - 8'h01;
        end
    end

    // Character decode of the held byte.
    wire is_band = (held_char == `BTD_CHAR_BAND);
    wire is_volt = (held_char == `BTD_CHAR_VOLT);
    wire is_exec = (held_char == `BTD_CHAR_EXEC);
    wire is_mode = (held_char == `BTD_CHAR_MODE);
    wire is_num = (held_char >= `BTD_CHAR_ZERO) && (held_char <= `BTD_CHAR_NINE);
    wire is_band_num = (held_char >= `BTD_CHAR_BAND_FIRST) && (held_char <= `BTD_CHAR_BAND_LAST);

    // Band pending state machine; decoder actions fire once at the strobe's trailing edge.
    btd_band_state_t band_state;
    btd_band_state_t next_band_state;
    wire strobe_end = strobe_last;
    wire band_pending = (band_state == BTD_BAND_WAIT);
    always_comb begin
        next_band_state = band_state;
        case (band_state)
            BTD_IDLE: begin
                if (strobe_end && is_band) begin
                    next_band_state = BTD_BAND_WAIT;
                end
            end
            BTD_BAND_WAIT: begin
                if (strobe_end) begin
                    next_band_state = is_band ? BTD_BAND_WAIT : BTD_IDLE;
                end
            end
            default: next_band_state = BTD_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            band_state <= BTD_IDLE;
        end else begin
            band_state <= next_band_state;
        end
    end

    // Band latch enable follows the strobe of the byte after the band command.
    wire next_latch = band_pending && strobe_active;
    wire take_band = band_pending && strobe_end && is_band_num;
    wire [1:0] band_idx = 2'(held_char - `BTD_CHAR_BAND_FIRST);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            remote_band_latch_enable_out <= 1'b0;
            band_select_out <= `BTD_BAND_RESET;
            data_strobe_out <= 1'b0;
        end else begin
            remote_band_latch_enable_out <= next_latch;
            data_strobe_out <= strobe_active;
            if (take_band) begin
                band_select_out <= 4'h1 << band_idx;
            end
        end
    end

    // Tuning entry flag and digit control.
    wire ends_entry = tuning_entry_out && (is_exec || is_band || is_mode);
    wire transfer = strobe_end && (is_exec || ends_entry);
    wire clear_digits = strobe_end && is_volt;
    wire shift_digit = strobe_end && is_num;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tuning_entry_out <= 1'b0;
            code_valid_out <= 1'b0;
        end else begin
            if (clear_digits) begin
                tuning_entry_out <= 1'b1;
            end else if (transfer) begin
                tuning_entry_out <= 1'b0;
            end
            if (transfer) begin
                code_valid_out <= 1'b1;
            end
        end
    end

    // Storage register output drives the converter code directly.
    btd_digit_store #(
        .DIGITS(`BTD_DIGITS)
    ) u_store (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(clear_digits),
        .shift_in(shift_digit),
        .digit_in(held_char[`BTD_DIGIT_LSB +: `BTD_DIGIT_WIDTH]),
        .transfer_in(transfer),
        .stored_out(tune_code_out)
    );

    // The strobe stays high for at least its first eight cycles once it starts.
    AST_STROBE_WIDTH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(strobe_active) |-> strobe_active [*8])
        else $error("Data strobe shorter than expected.");
    // An accepted byte loads the full strobe width into the counter.
    AST_STROBE_LOAD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (byte_start && !strobe_active) |=> strobe_cnt == 8'(STROBE_CYCLES))
        else $error("Strobe counter not loaded with its width.");
    // The strobe pin follows the internal strobe one cycle later.
    AST_STROBE_OUT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        data_strobe_out == $past(strobe_active))
        else $error("Strobe output does not follow the counter.");
    // A running strobe counts down by one every cycle.
    AST_STROBE_COUNTS_DOWN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        strobe_active |=> strobe_cnt == $past(strobe_cnt) - 8'h01)
        else $error("Strobe counter did not count down.");
    // The last strobe cycle is followed by a quiet cycle.
    AST_STROBE_ENDS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        strobe_last |=> !strobe_active)
        else $error("Strobe did not end after its last cycle.");
    // One rising valid edge gives one start pulse only.
    AST_START_ONCE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        byte_start |=> !byte_start)
        else $error("Byte start lasted more than one cycle.");
    // The held character cannot change under a running strobe.
    AST_CHAR_STABLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        strobe_active |=> $stable(held_char))
        else $error("Held character changed during strobe.");
    // An accepted byte captures the synchronised data lines.
    AST_CHAR_CAPTURE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (byte_start && !strobe_active) |=> held_char == $past(rx.data))
        else $error("Accepted character not captured.");
    // The second synchroniser stage copies the first.
    AST_SYNC_TWO_STAGE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sync2 == $past(sync1))
        else $error("Synchroniser stages out of step.");

    // No strobe starts while attention is true.
    AST_NO_DATA_IN_ATTN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rx.attention && !strobe_active) |=> !strobe_active)
        else $error("Strobe started during attention.");
    // No strobe starts while the device is not addressed to listen.
    AST_NO_DATA_UNLISTENED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!rx.listen && !strobe_active) |=> !strobe_active)
        else $error("Strobe started while not listening.");

    // A band command sets the pending flag at the strobe's end.
    AST_BAND_PENDING: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (strobe_end && is_band) |=> band_pending)
        else $error("Band command did not set pending flag.");
    // Only a band command can raise the pending flag.
    AST_PENDING_ONLY_BAND: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!band_pending && !(strobe_end && is_band)) |=> !band_pending)
        else $error("Pending flag set without band command.");
    // A byte other than a band command after the band command drops the pending flag.
    AST_PENDING_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (band_pending && strobe_end && !is_band) |=> !band_pending)
        else $error("Pending flag not cleared by following byte.");

    // The latch enable only rises after a pending flag.
    AST_LATCH_ONLY_PENDING: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(remote_band_latch_enable_out) |-> $past(band_pending))
        else $error("Band latch enable without pending flag.");
    // The strobe of the byte after the band command opens the latch.
    AST_LATCH_DURING_STROBE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (band_pending && strobe_active) |=> remote_band_latch_enable_out)
        else $error("Band latch enable missing during strobe.");
    // Without a strobe the latch stays closed.
    AST_LATCH_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !strobe_active |=> !remote_band_latch_enable_out)
        else $error("Band latch enable outside a strobe.");
    // The latch enable never stands without the strobe pin.
    AST_LATCH_WITH_STROBE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        remote_band_latch_enable_out |-> data_strobe_out)
        else $error("Band latch enable without data strobe.");

    // A taken band number leaves exactly one select line high.
    AST_ONE_HOT_BAND: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $past(take_band) |-> $onehot(band_select_out))
        else $error("Band select not one-hot.");
    // Band characters one to four select lines zero to three.
    AST_BAND_VALUE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take_band |=> band_select_out == (4'h1 << (held_char[1:0] - 2'h1)))
        else $error("Band select does not match band number.");
    // The band select holds unless a band number is taken.
    AST_BAND_HOLDS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !take_band |=> $stable(band_select_out))
        else $error("Band select changed without a band number.");

    // A voltage command sets the entry flag.
    AST_VOLT_SETS_ENTRY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        clear_digits |=> tuning_entry_out)
        else $error("Voltage command did not set entry flag.");
    // An execute command clears the entry flag.
    AST_EXEC_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (strobe_end && is_exec) |=> !tuning_entry_out)
        else $error("Execute did not clear entry flag.");
    // An execute command transfers the digits.
    AST_EXEC_TRANSFERS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (strobe_end && is_exec) |=> code_valid_out)
        else $error("Execute did not transfer the digits.");
    // A mode command during entry ends it and transfers.
    AST_ENTRY_END: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (strobe_end && tuning_entry_out && is_mode) |=> !tuning_entry_out ##0 code_valid_out)
        else $error("Mode during entry did not transfer.");
    // A band command during entry ends it.
    AST_BAND_ENDS_ENTRY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (strobe_end && tuning_entry_out && is_band) |=> !tuning_entry_out)
        else $error("Band during entry did not end it.");
    // The entry flag holds between voltage and transfer events.
    AST_ENTRY_HOLDS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!clear_digits && !transfer) |=> $stable(tuning_entry_out))
        else $error("Entry flag changed without an event.");

    // Only decimal digits enter the shift register.
    AST_BCD_RANGE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        shift_digit |-> held_char[3:0] <= 4'h9)
        else $error("Non-decimal digit shifted.");
    // Every stored digit is decimal, so the code is one of the converter levels.
    AST_CODE_BCD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tune_code_out[3:0] <= 4'h9 && tune_code_out[7:4] <= 4'h9 &&
        tune_code_out[11:8] <= 4'h9 && tune_code_out[15:12] <= 4'h9)
        else $error("Stored code holds a non-decimal digit.");
    // The converter code only changes on a transfer.
    AST_CODE_HOLDS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !transfer |=> $stable(tune_code_out))
        else $error("Converter code changed without transfer.");
    // Once a code has been transferred the valid flag stays high.
    AST_CODE_VALID_STICKY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        code_valid_out |=> code_valid_out)
        else $error("Code valid flag dropped.");
    // The valid flag only rises on a transfer.
    AST_VALID_ONLY_XFER: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!code_valid_out && !transfer) |=> !code_valid_out)
        else $error("Code valid flag rose without transfer.");
endmodule : btd_decoder

// file: hw/btd_digit_store.sv
// Four-digit tuning shift register with parallel storage register.
`timescale 1ns/1ps
`include "btd_consts.svh"
module btd_digit_store #(
    parameter int DIGITS = `BTD_DIGITS
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic shift_in,
    input wire logic [3:0] digit_in,
    input wire logic transfer_in,
    output logic [4*DIGITS-1:0] stored_out
);
    logic [4*DIGITS-1:0] shift_q;

    // New digit enters the first position; the oldest falls off the far end.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_q <= '0;
        end else if (clear_in) begin
            shift_q <= '0;
        end else if (shift_in) begin
            shift_q <= {shift_q[4*DIGITS-5:0], digit_in};
        end
    end

    // Parallel copy into the storage register on a transfer pulse.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stored_out <= '0;
        end else if (transfer_in) begin
            stored_out <= shift_q;
        end
    end

    AST_TRANSFER_COPIES: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        transfer_in |=> stored_out == $past(shift_q))
        else $error("Storage register did not copy shift register.");
    AST_SHIFT_IN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (shift_in && !clear_in) |=> shift_q[3:0] == $past(digit_in))
        else $error("Digit not shifted into first position.");
    AST_SHIFT_DROPS_OLDEST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (shift_in && !clear_in) |=> shift_q[4*DIGITS-1:4] == $past(shift_q[4*DIGITS-5:0]))
        else $error("Older digits not moved up by one position.");
    AST_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        clear_in |=> shift_q == '0)
        else $error("Shift register not cleared.");
endmodule : btd_digit_store

// file: hw/btd_pkg.sv
// Types shared by the bus band and tuning decoder.
package btd_pkg;
    typedef struct packed {
        logic attention;
        logic listen;
        logic valid;
        logic [6:0] data;
    } btd_char_t;

    typedef struct packed {
        logic [15:0] code;
        logic entry;
    } btd_tune_t;

    typedef enum logic [1:0] {
        BTD_IDLE = 2'b00,
        BTD_BAND_WAIT = 2'b01
    } btd_band_state_t;
endpackage : btd_pkg
